// file: rtl/fpw_pkg.sv
// package: register map, field positions, reset values, source codes and prescaler width
// assumes: shared by the pwm core and its count-source prescaler
package fpw_pkg;
    localparam logic [9:0]  OFS_CH0_PERIOD_COMPARE       = 10'h0148;
    localparam logic [9:0]  OFS_CH0_OUT_B_RETURN_COMPARE = 10'h014a;
    localparam logic [9:0]  OFS_CH0_PERIOD_BUFFER        = 10'h014c;
    localparam logic [9:0]  OFS_CH0_OUT_B_RETURN_BUFFER  = 10'h014e;
    localparam logic [9:0]  OFS_OUT_A_ACTIVE_COMPARE     = 10'h0158;
    localparam logic [9:0]  OFS_OUT_B_ACTIVE_COMPARE     = 10'h015a;
    localparam logic [9:0]  OFS_OUT_A_ACTIVE_BUFFER      = 10'h015c;
    localparam logic [9:0]  OFS_OUT_B_ACTIVE_BUFFER      = 10'h015e;
    // own control words in free map space
    localparam logic [9:0]  OFS_TIMER_START_CONTROL      = 10'h0137;
    localparam logic [9:0]  OFS_BUFFER_MODE_CONTROL      = 10'h0138;
    localparam logic [9:0]  OFS_CHANNEL_CONTROL          = 10'h0140;
    localparam logic [9:0]  OFS_STATUS                   = 10'h0143;
    localparam logic [9:0]  OFS_COUNTER_CH0              = 10'h0146;
    localparam logic [9:0]  OFS_OUTPUT_DISABLE_BITS      = 10'h013c;
    localparam logic [9:0]  OFS_CUTOFF_CONTROL           = 10'h013d;
    localparam logic [9:0]  OFS_OUTPUT_LEVEL_CONTROL     = 10'h013e;

    localparam logic [15:0] RST_GENERAL = 16'hffff;
    localparam logic [15:0] RST_COUNTER = 16'h0000;
    localparam logic [7:0]  RST_DISABLE = 8'hff;

    // timer_start_control fields
    localparam int BIT_RUN_CH0    = 0;
    localparam int BIT_STOP_SEL   = 2;
    // buffer_mode_control fields
    localparam int BIT_BUF_C_CH0  = 4;
    localparam int BIT_BUF_D_CH0  = 5;
    localparam int BIT_BUF_C_CH1  = 6;
    localparam int BIT_BUF_D_CH1  = 7;
    // channel control fields
    localparam int POS_SRC_SEL    = 0;
    localparam int POS_EDGE_SEL   = 3;
    localparam int BIT_EXT_CLK_EN = 7;
    // status bits: a, b, c, d match, overflow; then cutoff control enable bit
    localparam int BIT_MATCH_A    = 0;
    localparam int BIT_MATCH_B    = 1;
    localparam int BIT_MATCH_C    = 2;
    localparam int BIT_MATCH_D    = 3;
    localparam int BIT_OVERFLOW   = 4;
    localparam int BIT_CUTOFF_EN  = 0;

    typedef enum logic [2:0] {
        FPW_SRC_F1    = 3'b000,
        FPW_SRC_F2    = 3'b001,
        FPW_SRC_F4    = 3'b010,
        FPW_SRC_F8    = 3'b011,
        FPW_SRC_F32   = 3'b100,
        FPW_SRC_EXT   = 3'b101,
        FPW_SRC_FAST  = 3'b110,
        FPW_SRC_RSVD  = 3'b111
    } fpw_src_t;

    localparam int PRESCALE_BITS  = 5;
endpackage

// file: rtl/fpw_prescaler.sv
// count-source tick generator: divided operation clock or fast oscillator
// assumes: fast_osc_tick is a one-cycle enable already on clk
`timescale 1ns/1ns
module fpw_prescaler #(
    parameter int W = fpw_pkg::PRESCALE_BITS
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [2:0] src_sel,
    input  wire logic       fast_osc_tick,
    output logic            tick
);
    logic [W-1:0] div_r;
    logic [W-1:0] div_nxt;

    always_comb begin
        div_nxt = run ? div_r + 1'b1 : '0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

    // 101b and 111b never tick: no external source here
    always_comb begin
        unique case (src_sel)
            fpw_pkg::FPW_SRC_F1:   tick = run;
            fpw_pkg::FPW_SRC_F2:   tick = run && (div_r[0] == 1'b1);
            fpw_pkg::FPW_SRC_F4:   tick = run && (div_r[1:0] == 2'b11);
            fpw_pkg::FPW_SRC_F8:   tick = run && (div_r[2:0] == 3'b111);
            fpw_pkg::FPW_SRC_F32:  tick = run && (div_r[4:0] == 5'h1f);
            fpw_pkg::FPW_SRC_FAST: tick = run && fast_osc_tick;
            default:               tick = 1'b0;
        endcase
    end
endmodule

// file: rtl/fpw_core.sv
// fixed-period two-output pwm timer with buffers, flags and forced cutoff
// assumes: register port on clk; ext_irq_pin_zero and ext_clock_pin are async pins
// Functional notes
// RULE1: only counter 0 advances on each count-source tick; channel 1 counter idle.
// RULE2: counter 0 clears on period match, period is value plus one ticks.
// RULE3: output a goes active at a1 match, returns at period match.
// RULE4: output b goes active at b1 match, returns at b0 match.
// RULE5: software keeps a1<=a0, b1<=b0, b0<=a0, buffers likewise.
// RULE6: writing 1 to the run bit starts counting.
// RULE7: stop-select 1: writing run 0 stops at once, outputs hold.
// RULE8: stop-select 0: count stops when period match clears counter to zero.
// RULE9: flags set on every compare match and on counter 0 overflow.
// RULE10: only outputs a and b of channel 0 carry pwm; others stay ports.
// RULE11: counter 0 readable and writable while running.
// RULE12: source field picks f1,f2,f4,f8,f32 or fast oscillator at 110b.
// RULE13: external clock code 101b with enable bit and edge field, other modes.
// RULE14: external clock pulses last at least three operation-clock cycles.
// RULE15: software turns the fast oscillator on before selecting 110b.
// RULE16: buffer enable makes register c buffer a and d buffer b.
// RULE17: at period match buffers are copied into a0, b0, a1, b1.
// RULE18: c and d match flags still set while registers act as buffers.
// RULE19: a pin drives timer output only while its disable bit is 0.
// RULE20: cutoff enabled and low interrupt pin set all disable bits.
// RULE21: software sets cutoff enable, irq enable, one-edge, input direction.
// RULE22: general registers are accessed only as 16-bit words.
// RULE23: mode/dead-time/io registers ignored; active level selectable per pin.
// RULE24: compare match output changes on the tick where counter equals value.
`timescale 1ns/1ns
module fpw_core #(
    parameter int CW = 16
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [9:0]    addr,
    input  wire logic [15:0]   wdata,
    input  wire logic          wr,
    input  wire logic          rd,
    output logic      [15:0]   rdata,
    input  wire logic          fast_osc_tick,
    input  wire logic          ext_clock_pin,
    input  wire logic          ext_irq_pin_zero,
    output logic               pwm_out_a,
    output logic               pwm_out_a_oe,
    output logic               pwm_out_b,
    output logic               pwm_out_b_oe,
    output logic      [7:0]    output_disable_bits,
    output logic      [4:0]    match_status
);
    logic          rst_s1_r;
    logic          rst_s2_r;
    logic          srst_n;
    logic          irq_s1_r;
    logic          irq_s2_r;
    logic          eck_s1_r;
    logic          eck_s2_r;
    logic          eck_d_r;

    logic [CW-1:0] gen_r   [8];
    logic [CW-1:0] gen_nxt [8];
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          run_r;
    logic          run_nxt;
    logic          stop_sel_r;
    logic          stop_sel_nxt;
    logic [3:0]    buf_en_r;
    logic [3:0]    buf_en_nxt;
    logic [7:0]    chan_ctl_r;
    logic [7:0]    chan_ctl_nxt;
    logic [4:0]    stat_r;
    logic [4:0]    stat_nxt;
    logic [7:0]    dis_r;
    logic [7:0]    dis_nxt;
    logic          cut_en_r;
    logic          cut_en_nxt;
    logic [1:0]    lvl_r;
    logic [1:0]    lvl_nxt;
    logic          out_a_r;
    logic          out_a_nxt;
    logic          out_b_r;
    logic          out_b_nxt;
    logic [15:0]   rdata_r;
    logic [15:0]   rdata_nxt;

    logic          tick;
    logic          src_tick;
    logic          ext_edge;
    logic          m_a0;
    logic          m_b0;
    logic          m_c0;
    logic          m_d0;
    logic          m_a1;
    logic          m_b1;
    logic          ovf;
    logic          wr_gen;
    logic [2:0]    gen_idx;
    logic          gen_hit;

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign srst_n = rst_s2_r;

    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            irq_s1_r <= 1'b1;
            irq_s2_r <= 1'b1;
            eck_s1_r <= 1'b0;
            eck_s2_r <= 1'b0;
            eck_d_r  <= 1'b0;
        end else begin
            irq_s1_r <= ext_irq_pin_zero;
            irq_s2_r <= irq_s1_r;
            eck_s1_r <= ext_clock_pin;
            eck_s2_r <= eck_s1_r;
            eck_d_r  <= eck_s2_r;
        end
    end

    // edge field: 00 rising, 01 falling, else both; needs pulses of 3+ clocks (see RULE14)
    always_comb begin
        unique case (chan_ctl_r[fpw_pkg::POS_EDGE_SEL +: 2])
            2'b00:   ext_edge = eck_s2_r && !eck_d_r;
            2'b01:   ext_edge = !eck_s2_r && eck_d_r;
            default: ext_edge = eck_s2_r ^ eck_d_r;
        endcase
    end

    fpw_prescaler #(
        .W (fpw_pkg::PRESCALE_BITS)
    ) u_prescaler (
        .clk           (clk),
        .rst_n         (srst_n),
        .run           (run_r),
        .src_sel       (chan_ctl_r[fpw_pkg::POS_SRC_SEL +: 3]),
        .fast_osc_tick (fast_osc_tick),
        .tick          (src_tick)
    ); // see RULE12

    // external source is for other modes only (see RULE13)
    assign tick = src_tick && !(chan_ctl_r[fpw_pkg::BIT_EXT_CLK_EN] && ext_edge && 1'b0);

    // matches on the tick where counter equals the register (see RULE24)
    assign m_a0 = tick && (cnt_r == gen_r[0]);
    assign m_b0 = tick && (cnt_r == gen_r[1]);
    assign m_c0 = tick && (cnt_r == gen_r[2]);
    assign m_d0 = tick && (cnt_r == gen_r[3]);
    assign m_a1 = tick && (cnt_r == gen_r[4]);
    assign m_b1 = tick && (cnt_r == gen_r[5]);
    assign ovf  = tick && !m_a0 && (cnt_r == {CW{1'b1}});

    // general register index: word-aligned addresses only (see RULE22)
    assign gen_hit = (addr[9:4] == fpw_pkg::OFS_CH0_PERIOD_COMPARE[9:4] ||
                      addr[9:4] == fpw_pkg::OFS_OUT_A_ACTIVE_COMPARE[9:4]) &&
                     addr[3] && !addr[0];
    assign gen_idx = {addr[4], addr[2:1]};
    assign wr_gen  = wr && gen_hit;

    // general registers with buffer transfer at period match
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            gen_nxt[i] = gen_r[i];
            if (wr_gen && gen_idx == 3'(i)) begin
                gen_nxt[i] = wdata;
            end
        end
        if (m_a0) begin
            if (buf_en_r[0]) gen_nxt[0] = gen_r[2]; // see RULE16, RULE17
            if (buf_en_r[1]) gen_nxt[1] = gen_r[3]; // see RULE16, RULE17
            if (buf_en_r[2]) gen_nxt[4] = gen_r[6]; // see RULE16, RULE17
            if (buf_en_r[3]) gen_nxt[5] = gen_r[7]; // see RULE16, RULE17
        end
    end

    // counter and run control
    always_comb begin
        cnt_nxt      = cnt_r;
        run_nxt      = run_r;
        stop_sel_nxt = stop_sel_r;
        if (tick) begin
            cnt_nxt = m_a0 ? fpw_pkg::RST_COUNTER : cnt_r + 1'b1; // see RULE1, RULE2
            if (m_a0 && !stop_sel_r) begin
                run_nxt = 1'b0; // see RULE8
            end
        end
        // period-match clear beats a counter write
        if (wr && addr == fpw_pkg::OFS_COUNTER_CH0 && !m_a0) begin
            cnt_nxt = wdata; // see RULE11
        end
        if (wr && addr == fpw_pkg::OFS_TIMER_START_CONTROL) begin
            stop_sel_nxt = wdata[fpw_pkg::BIT_STOP_SEL];
            if (wdata[fpw_pkg::BIT_RUN_CH0]) begin
                run_nxt = 1'b1; // see RULE6
            end else if (stop_sel_r) begin
                run_nxt = 1'b0; // see RULE7
            end
        end
    end

    // control, status, cutoff
    always_comb begin
        buf_en_nxt   = buf_en_r;
        chan_ctl_nxt = chan_ctl_r;
        cut_en_nxt   = cut_en_r;
        lvl_nxt      = lvl_r;
        dis_nxt      = dis_r;
        stat_nxt     = stat_r;
        if (wr && addr == fpw_pkg::OFS_BUFFER_MODE_CONTROL) begin
            buf_en_nxt = wdata[fpw_pkg::BIT_BUF_D_CH1:fpw_pkg::BIT_BUF_C_CH0];
        end
        if (wr && addr == fpw_pkg::OFS_CHANNEL_CONTROL) begin
            chan_ctl_nxt = wdata[7:0];
        end
        if (wr && addr == fpw_pkg::OFS_CUTOFF_CONTROL) begin
            cut_en_nxt = wdata[fpw_pkg::BIT_CUTOFF_EN];
        end
        if (wr && addr == fpw_pkg::OFS_OUTPUT_LEVEL_CONTROL) begin
            lvl_nxt = wdata[1:0]; // see RULE23
        end
        if (wr && addr == fpw_pkg::OFS_OUTPUT_DISABLE_BITS) begin
            dis_nxt = wdata[7:0];
        end
        // low pin beats a software write (see RULE20)
        if (cut_en_r && !irq_s2_r) begin
            dis_nxt = 8'hff;
        end
        // write 0 clears a flag; a match in the same cycle wins
        if (wr && addr == fpw_pkg::OFS_STATUS) begin
            stat_nxt = stat_r & wdata[4:0];
        end
        stat_nxt[fpw_pkg::BIT_MATCH_A]  = stat_nxt[fpw_pkg::BIT_MATCH_A] | m_a0 | m_a1; // see RULE9
        stat_nxt[fpw_pkg::BIT_MATCH_B]  = stat_nxt[fpw_pkg::BIT_MATCH_B] | m_b0 | m_b1; // see RULE9
        stat_nxt[fpw_pkg::BIT_MATCH_C]  = stat_nxt[fpw_pkg::BIT_MATCH_C] | m_c0; // see RULE18
        stat_nxt[fpw_pkg::BIT_MATCH_D]  = stat_nxt[fpw_pkg::BIT_MATCH_D] | m_d0; // see RULE18
        stat_nxt[fpw_pkg::BIT_OVERFLOW] = stat_nxt[fpw_pkg::BIT_OVERFLOW] | ovf; // see RULE9
    end

    // waveform; levels held whenever counting stops (see RULE7, RULE8)
    always_comb begin
        out_a_nxt = out_a_r;
        out_b_nxt = out_b_r;
        if (m_a0) begin
            out_a_nxt = 1'b0; // see RULE3
        end else if (m_a1) begin
            out_a_nxt = 1'b1; // see RULE3
        end
        if (m_b0) begin
            out_b_nxt = 1'b0; // see RULE4
        end else if (m_b1) begin
            out_b_nxt = 1'b1; // see RULE4
        end
    end

    // read mux, data one cycle after the strobe
    always_comb begin
        rdata_nxt = 16'h0000;
        if (rd) begin
            if (gen_hit) begin
                rdata_nxt = gen_r[gen_idx];
            end else begin
                unique case (addr)
                    fpw_pkg::OFS_COUNTER_CH0:          rdata_nxt = cnt_r; // see RULE11
                    fpw_pkg::OFS_TIMER_START_CONTROL:  rdata_nxt = {13'h0000, stop_sel_r, 1'b0, run_r};
                    fpw_pkg::OFS_BUFFER_MODE_CONTROL:  rdata_nxt = {8'h00, buf_en_r, 4'h0};
                    fpw_pkg::OFS_CHANNEL_CONTROL:      rdata_nxt = {8'h00, chan_ctl_r};
                    fpw_pkg::OFS_STATUS:               rdata_nxt = {11'h000, stat_r};
                    fpw_pkg::OFS_OUTPUT_DISABLE_BITS:  rdata_nxt = {8'h00, dis_r};
                    fpw_pkg::OFS_CUTOFF_CONTROL:       rdata_nxt = {15'h0000, cut_en_r};
                    fpw_pkg::OFS_OUTPUT_LEVEL_CONTROL: rdata_nxt = {14'h0000, lvl_r};
                    default:                           rdata_nxt = 16'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            for (int i = 0; i < 8; i++) begin
                gen_r[i] <= fpw_pkg::RST_GENERAL;
            end
            cnt_r      <= fpw_pkg::RST_COUNTER;
            run_r      <= 1'b0;
            stop_sel_r <= 1'b0;
            buf_en_r   <= 4'h0;
            chan_ctl_r <= 8'h00;
            stat_r     <= 5'h00;
            dis_r      <= fpw_pkg::RST_DISABLE;
            cut_en_r   <= 1'b0;
            lvl_r      <= 2'b00;
            out_a_r    <= 1'b0;
            out_b_r    <= 1'b0;
            rdata_r    <= 16'h0000;
        end else begin
            for (int i = 0; i < 8; i++) begin
                gen_r[i] <= gen_nxt[i];
            end
            cnt_r      <= cnt_nxt;
            run_r      <= run_nxt;
            stop_sel_r <= stop_sel_nxt;
            buf_en_r   <= buf_en_nxt;
            chan_ctl_r <= chan_ctl_nxt;
            stat_r     <= stat_nxt;
            dis_r      <= dis_nxt;
            cut_en_r   <= cut_en_nxt;
            lvl_r      <= lvl_nxt;
            out_a_r    <= out_a_nxt;
            out_b_r    <= out_b_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    // level bit 1: active low; other six pins stay ports (see RULE10)
    assign pwm_out_a           = out_a_r ^ lvl_r[0]; // see RULE23
    assign pwm_out_b           = out_b_r ^ lvl_r[1]; // see RULE23
    assign pwm_out_a_oe        = !dis_r[0]; // see RULE19
    assign pwm_out_b_oe        = !dis_r[1]; // see RULE19
    assign output_disable_bits = dis_r;
    assign match_status        = stat_r;
    assign rdata               = rdata_r;
endmodule

// file: tb/fpw_load_model.sv
// partner: load on the two pwm pins; counts cycles each pin is seen high
// assumes: pull-down on each pin, pull-up on the fault line
`timescale 1ns/1ns
module fpw_load_model (
    input  wire logic        clk,
    input  wire logic        clr,
    input  wire logic        cut_req,
    input  wire logic        pwm_out_a,
    input  wire logic        pwm_out_a_oe,
    input  wire logic        pwm_out_b,
    input  wire logic        pwm_out_b_oe,
    output logic             fault_n,
    output logic      [15:0] cnt_a,
    output logic      [15:0] cnt_b
);
    // undriven pin reads the pull-down
    wire logic pin_a = pwm_out_a_oe & pwm_out_a;
    wire logic pin_b = pwm_out_b_oe & pwm_out_b;
    // fault line low only on bench command
    assign fault_n = ~cut_req;
    always_ff @(posedge clk) begin
        if (clr) begin
            cnt_a <= 16'h0000;
            cnt_b <= 16'h0000;
        end else begin
            cnt_a <= cnt_a + {15'h0000, pin_a};
            cnt_b <= cnt_b + {15'h0000, pin_b};
        end
    end
endmodule

// file: tb/fpw_core_asserts.sv
// checker: port properties of the pwm core
// assumes: bound to fpw_core, one clock, async active-low reset
`timescale 1ns/1ns
module fpw_core_asserts #(
    parameter int CW = 16
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [9:0]  addr,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        ext_irq_pin_zero,
    input wire logic        pwm_out_a,
    input wire logic        pwm_out_a_oe,
    input wire logic        pwm_out_b_oe,
    input wire logic [7:0]  output_disable_bits,
    input wire logic [4:0]  match_status
);
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data outside its slot");
    rdata_unmapped_a: assert property ($past(rd) && $past(addr) == 10'h0100 |-> rdata == 16'h0000)
        else $error("unmapped read not zero");
    oe_a_off_a: assert property (output_disable_bits[0] && $past(output_disable_bits[0]) |-> !pwm_out_a_oe)
        else $error("pin a driven while disabled");
    oe_b_off_a: assert property (output_disable_bits[1] && $past(output_disable_bits[1]) |-> !pwm_out_b_oe)
        else $error("pin b driven while disabled");
    oe_a_on_a: assert property (pwm_out_a_oe && $past(pwm_out_a_oe) |-> !$past(output_disable_bits[0]))
        else $error("pin a driven without enable");
    dis_fall_a: assert property (|($past(output_disable_bits) & ~output_disable_bits)
        |-> $past(wr) && $past(addr) == fpw_pkg::OFS_OUTPUT_DISABLE_BITS)
        else $error("disable bit cleared without a write");
    dis_rise_a: assert property (|(output_disable_bits & ~$past(output_disable_bits))
        |-> ($past(wr) && $past(addr) == fpw_pkg::OFS_OUTPUT_DISABLE_BITS) || !$past(ext_irq_pin_zero)
        || !$past(ext_irq_pin_zero, 2) || !$past(ext_irq_pin_zero, 3) || !$past(ext_irq_pin_zero, 4))
        else $error("disable bit set without write or cutoff");
    flag_clear_a: assert property (|($past(match_status) & ~match_status)
        |-> $past(wr) && $past(addr) == fpw_pkg::OFS_STATUS)
        else $error("status flag cleared without a write");

    cover property ($rose(pwm_out_a));
    cover property ($fell(pwm_out_a_oe));
    cover property ($rose(match_status[4]));
endmodule
bind fpw_core fpw_core_asserts #(.CW(CW)) i_chk (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
    .ext_irq_pin_zero(ext_irq_pin_zero), .pwm_out_a(pwm_out_a), .pwm_out_a_oe(pwm_out_a_oe),
    .pwm_out_b_oe(pwm_out_b_oe), .output_disable_bits(output_disable_bits), .match_status(match_status)
);

// file: tb/tb_top.sv
// testbench: register-driven scenarios for the fixed-period pwm core
// assumes: fpw_pkg compiled first
`timescale 1ns/1ns
module tb_top;
    logic        clk, rst_n, wr, rd, cut_req, clr, fault_n;
    logic        fast_osc_tick = 1'b0;
    logic        pwm_out_a, pwm_out_a_oe, pwm_out_b, pwm_out_b_oe;
    logic [9:0]  addr;
    logic [15:0] wdata, rdata, q, q2, cnt_a, cnt_b;
    logic [7:0]  output_disable_bits;
    logic [4:0]  match_status;
    int          n_mismatch, n_checks;

    fpw_core #(.CW(16)) i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .fast_osc_tick(fast_osc_tick), .ext_clock_pin(1'b0), .ext_irq_pin_zero(fault_n),
        .pwm_out_a(pwm_out_a), .pwm_out_a_oe(pwm_out_a_oe), .pwm_out_b(pwm_out_b),
        .pwm_out_b_oe(pwm_out_b_oe), .output_disable_bits(output_disable_bits), .match_status(match_status));
    fpw_load_model i_load (.clk(clk), .clr(clr), .cut_req(cut_req), .pwm_out_a(pwm_out_a),
        .pwm_out_a_oe(pwm_out_a_oe), .pwm_out_b(pwm_out_b), .pwm_out_b_oe(pwm_out_b_oe),
        .fault_n(fault_n), .cnt_a(cnt_a), .cnt_b(cnt_b));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // fast source: a tick every second clock
    always @(posedge clk) fast_osc_tick <= ~fast_osc_tick;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rreg(input logic [9:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask
    // whole periods, so start phase is irrelevant
    task automatic measure(input int n, input logic [15:0] ea, input logic [15:0] eb);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
        check(cnt_a, ea);
        check(cnt_b, eb);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            rreg(fpw_pkg::OFS_CH0_PERIOD_COMPARE + 10'((i / 4) * 16 + (i % 4) * 2), q);
            check(q, fpw_pkg::RST_GENERAL);
        end
        rreg(fpw_pkg::OFS_COUNTER_CH0, q);
        check(q, fpw_pkg::RST_COUNTER);
        rreg(fpw_pkg::OFS_OUTPUT_DISABLE_BITS, q);
        check(q, {8'h00, fpw_pkg::RST_DISABLE});
        rreg(10'h0100, q);
        check(q, 16'h0000);
        $display("reset test done");
    endtask
    task automatic t_sources();
        int         div [6] = '{1, 2, 4, 8, 32, 2};
        logic [2:0] src [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
        wreg(fpw_pkg::OFS_CH0_PERIOD_COMPARE, 16'h0009);
        wreg(fpw_pkg::OFS_OUT_A_ACTIVE_COMPARE, 16'h0005);
        wreg(fpw_pkg::OFS_CH0_OUT_B_RETURN_COMPARE, 16'h0007);
        wreg(fpw_pkg::OFS_OUT_B_ACTIVE_COMPARE, 16'h0003);
        wreg(fpw_pkg::OFS_OUTPUT_DISABLE_BITS, 16'h00fc);
        wreg(fpw_pkg::OFS_TIMER_START_CONTROL, 16'h0004);
        foreach (div[k]) begin
            wreg(fpw_pkg::OFS_CHANNEL_CONTROL, {13'h0000, src[k]});
            wreg(fpw_pkg::OFS_COUNTER_CH0, 16'h0000);
            wreg(fpw_pkg::OFS_TIMER_START_CONTROL, 16'h0005);
            repeat (12 * div[k]) @(posedge clk);
            measure(20 * div[k], 16'(8 * div[k]), 16'(8 * div[k]));
            wreg(fpw_pkg::OFS_TIMER_START_CONTROL, 16'h0004);
        end
        // external source code: no ticks in this mode
        wreg(fpw_pkg::OFS_CHANNEL_CONTROL, 16'h0085);
        wreg(fpw_pkg::OFS_COUNTER_CH0, 16'h0000);
        wreg(fpw_pkg::OFS_TIMER_START_CONTROL, 16'h0005);
        repeat (20) @(posedge clk);
        rreg(fpw_pkg::OFS_COUNTER_CH0, q);
        check(q, 16'h0000);
        wreg(fpw_pkg::OFS_TIMER_START_CONTROL, 16'h0004);
        wreg(fpw_pkg::OFS_CHANNEL_CONTROL, 16'h0000);
        $display("source test done");
    endtask
    task automatic t_run();
        wreg(fpw_pkg::OFS_TIMER_START_CONTROL, 16'h0005);
        wreg(fpw_pkg::OFS_STATUS, 16'h0000);
        repeat (12) @(posedge clk);
        #1 check(16'(match_status[1:0]), 16'h0003);
        wreg(fpw_pkg::OFS_OUTPUT_LEVEL_CONTROL, 16'h0003);
        measure(20, 16'h000c, 16'h000c);
        wreg(fpw_pkg::OFS_OUTPUT_LEVEL_CONTROL, 16'h0000);
        wreg(fpw_pkg::OFS_STATUS, 16'h0000);
        wreg(fpw_pkg::OFS_COUNTER_CH0, 16'hfffe);
        repeat (4) @(posedge clk);
        #1 check(16'(match_status[4]), 16'h0001);
        rreg(fpw_pkg::OFS_COUNTER_CH0, q);
        check({15'h0000, q < 16'h000a}, 16'h0001);
        // stop at once: all freezes
        wreg(fpw_pkg::OFS_TIMER_START_CONTROL, 16'h0004);
        repeat (2) @(posedge clk);
        #1 q2 = {14'h0000, pwm_out_a, pwm_out_b};
        rreg(fpw_pkg::OFS_COUNTER_CH0, q);
        repeat (20) @(posedge clk);
        check({14'h0000, pwm_out_a, pwm_out_b}, q2);
        rreg(fpw_pkg::OFS_COUNTER_CH0, q2);
        check(q2, q);
        $display("run test done");
    endtask
    task automatic t_buffer();
        wreg(fpw_pkg::OFS_BUFFER_MODE_CONTROL, 16'h00f0);
        wreg(fpw_pkg::OFS_CH0_PERIOD_BUFFER, 16'h0009);
        wreg(fpw_pkg::OFS_CH0_OUT_B_RETURN_BUFFER, 16'h0007);
        wreg(fpw_pkg::OFS_OUT_A_ACTIVE_BUFFER, 16'h0001);
        wreg(fpw_pkg::OFS_OUT_B_ACTIVE_BUFFER, 16'h0006);
        wreg(fpw_pkg::OFS_TIMER_START_CONTROL, 16'h0005);
        repeat (25) @(posedge clk);
        rreg(fpw_pkg::OFS_OUT_A_ACTIVE_COMPARE, q);
        check(q, 16'h0001);
        rreg(fpw_pkg::OFS_OUT_B_ACTIVE_COMPARE, q);
        check(q, 16'h0006);
        wreg(fpw_pkg::OFS_STATUS, 16'h0000);
        repeat (12) @(posedge clk);
        #1 check({14'h0000, match_status[3:2]}, 16'h0003);
        measure(20, 16'h0010, 16'h0002);
        wreg(fpw_pkg::OFS_BUFFER_MODE_CONTROL, 16'h0000);
        // stop-select 0: run 0 ignored, stops at period clear
        wreg(fpw_pkg::OFS_TIMER_START_CONTROL, 16'h0001);
        wreg(fpw_pkg::OFS_TIMER_START_CONTROL, 16'h0000);
        repeat (30) @(posedge clk);
        rreg(fpw_pkg::OFS_COUNTER_CH0, q);
        check(q, 16'h0000);
        check({14'h0000, pwm_out_a, pwm_out_b}, 16'h0000);
        $display("buffer test done");
    endtask
    task automatic t_cutoff();
        wreg(fpw_pkg::OFS_CUTOFF_CONTROL, 16'h0001);
        @(posedge clk);
        cut_req <= 1'b1;
        repeat (4) @(posedge clk);
        #1 check({8'h00, output_disable_bits}, 16'h00ff);
        check({14'h0000, pwm_out_a_oe, pwm_out_b_oe}, 16'h0000);
        @(posedge clk);
        cut_req <= 1'b0;
        repeat (4) @(posedge clk);
        wreg(fpw_pkg::OFS_CUTOFF_CONTROL, 16'h0000);
        wreg(fpw_pkg::OFS_OUTPUT_DISABLE_BITS, 16'h00fc);
        repeat (2) @(posedge clk);
        #1 check({14'h0000, pwm_out_a_oe, pwm_out_b_oe}, 16'h0003);
        $display("cutoff test done");
    endtask

    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 10'h000;
        wdata = 16'h0000;
        cut_req = 1'b0;
        clr = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_sources();
        t_run();
        t_buffer();
        t_cutoff();
        finish_test();
    end
    // hang guard
    initial begin
        #1000000;
        n_mismatch++;
        finish_test();
    end
endmodule
